// ==== rtl/rbpc_pkg.sv ====
// Purpose: Shared constants for the reset and bitstream pin control block.
// Assumes: sys_clk at 50 MHz; AXI4-Lite register bus with 32-bit data.
// Notes: Times are kept in ns and turned into cycle counts here.
package rbpc_pkg;
  localparam int CLK_PERIOD_NS = 20;
  // Half of a digital master clock period; the pulse width rounds up.
  localparam int DIGITAL_MASTER_CLOCK_HALF_NS = 125;
  localparam int DIGITAL_MASTER_CLOCK_HALF_CYC = (DIGITAL_MASTER_CLOCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest gap between master clock edges before the clock is taken as idle.
  localparam int MCLK_IDLE_NS = 2000;
  localparam int MCLK_IDLE_CYC = (MCLK_IDLE_NS / CLK_PERIOD_NS < 1) ? 1 : MCLK_IDLE_NS / CLK_PERIOD_NS;
  // Settling time of the input structure when the master clock was idle in reset.
  localparam int STARTUP_NS = 10000;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  localparam int DR_CNT_W = 8;
  localparam int FIFO_WIDTH = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_CNT_W = 4;
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 4'h4;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_EXTREF_BIT = 1;
  localparam logic CTRL_EN_RST = 1'h0;
  localparam logic CTRL_EXTREF_RST = 1'h0;
  localparam int ST_MODE_BIT = 0;
  localparam int ST_STRAP_BIT = 1;
  localparam int ST_RESET_BIT = 2;
  localparam int ST_MCLK_BIT = 3;
  localparam int ST_OPER_BIT = 4;
  localparam int ST_FIFO_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/rbpc_fifo.sv ====
// Purpose: Small flop-based FIFO with valid and ready on both sides.
// Assumes: One clock; arst_n asserts asynchronously, srst_n acts on the clock.
// Notes: A push and a pop in the same cycle are both taken when neither empty nor full.
`timescale 1ns/1ps
module rbpc_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  // Clock and resets.
  input wire logic clk,
  input wire logic arst_n,
  input wire logic srst_n,
  // Fill side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // Fill level.
  output logic [CNT_W-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CNT_W-1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != CNT_W'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign level = cnt_r;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else if (!srst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= PW'(rd_ptr_r + 1'b1);
      end
      if (push && !pop) begin
        cnt_r <= CNT_W'(cnt_r + 1'b1);
      end else if (pop && !push) begin
        cnt_r <= CNT_W'(cnt_r - 1'b1);
      end
    end
  end
endmodule

// ==== rtl/rbpc_top.sv ====
// Purpose: Reset pin, interface mode, strap and modulator output pin control.
// Assumes: Pins are asynchronous to sys_clk; conv_done, watchdog_reset and the
//   modulator stream come from logic on sys_clk.
// Notes: Software reaches the control and status words over AXI4-Lite.
// Behaviour
// - In serial mode a low reset pin puts the whole block in reset with all registers at default; bus, mode and strap registers here reset on rst_b only.
// - While the reset pin is low the serial interface takes no transaction.
// - In reset the core clock is gated and only the input structure runs, and only with a live master clock.
// - The state held during pin reset is the same as after power-on reset.
// - Converters stay biased in reset and run at once on release if the master clock ran meanwhile.
// - In 2-wire mode the reset pin is the low oversampling strap, caught on entry and at each watchdog reset.
// - Reference select at 1 turns the internal reference off, at 0 turns it on and onto the reference pin.
// - Both bitstream pins float while the output enable bit is low.
// - When enabled, channel 0 and channel 1 bitstreams drive the two pins, updated at the analog clock rate.
// - While bitstream outputs are enabled the conversion-ready output is held inactive.
// - In 2-wire mode both bitstream pins float whatever the enable bit says.
// - The mode pin is caught after power-on, master and watchdog reset; high means 2-wire mode.
// - With bitstreams off, each finished conversion gives a low pulse half a digital clock period wide.
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rbpc_top (
  // Clock and system reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pins.
  input wire logic reset_oversampling_select_low_strap_pin,
  input wire logic mode_pin,
  input wire logic analog_master_clock,
  output logic bitstream_out_ch0,
  output logic bitstream_out_ch0_oe,
  output logic bitstream_out_ch1,
  output logic bitstream_out_ch1_oe,
  output logic conversion_ready_out,
  output logic conversion_ready_oe,
  // Core events and modulator stream.
  input wire logic watchdog_reset,
  input wire logic conv_done,
  input wire logic mod_valid,
  input wire logic [rbpc_pkg::FIFO_WIDTH-1:0] mod_data,
  output logic mod_ready,
  // Core controls and status.
  output logic core_clk_en,
  output logic input_clk_en,
  output logic adc_bias_en,
  output logic conv_operational,
  output logic serial_if_enable,
  output logic two_wire_mode,
  output logic oversampling_select_low_strap,
  output logic internal_ref_en,
  output logic ref_pin_switch,
  // AXI4-Lite write channels.
  input wire logic [rbpc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [rbpc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic pin_s1_r, pin_s2_r, mode_s1_r, mode_s2_r, am_s1_r, am_s2_r, am_s3_r;
  logic rs1_r, rs2_r, core_prev_r, por_done_r, mode_2w_r, strap_r;
  logic mclk_active_r, en_r, extref_r, bs0_r, bs1_r, dr_n_r;
  logic [rbpc_pkg::CNT_W-1:0] idle_cnt_r, su_cnt_r;
  logic [rbpc_pkg::DR_CNT_W-1:0] dr_cnt_r, dr_low_len_r;
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [rbpc_pkg::AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic hard_arst_n, core_arst_n, in_reset, am_rise, mode_sample, enter_2w, wr_do, rd_do;
  logic drive_en, fifo_ovalid, fifo_oready;
  logic [rbpc_pkg::FIFO_WIDTH-1:0] fifo_odata;
  logic [rbpc_pkg::FIFO_CNT_W-1:0] fifo_level;

  function automatic logic is_mapped(input logic [rbpc_pkg::AXI_AW-1:0] a);
    is_mapped = (a == rbpc_pkg::ADDR_CTRL) || (a == rbpc_pkg::ADDR_STATUS);
  endfunction

  // Pins pass two flops before logic reads them; only hard_arst_n takes the raw reset pin.
  always_ff @(posedge sys_clk) begin
    pin_s1_r <= reset_oversampling_select_low_strap_pin;
    pin_s2_r <= pin_s1_r;
    mode_s1_r <= mode_pin;
    mode_s2_r <= mode_s1_r;
    am_s1_r <= analog_master_clock;
    am_s2_r <= am_s1_r;
    am_s3_r <= am_s2_r;
  end
  assign am_rise = am_s2_r & ~am_s3_r;

  // The raw pin acts as a reset only in serial mode; in 2-wire mode it is a strap.
  assign hard_arst_n = reset_oversampling_select_low_strap_pin | mode_2w_r;
  always_ff @(posedge sys_clk or negedge hard_arst_n) begin
    if (!hard_arst_n) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  assign core_arst_n = rs2_r;
  assign in_reset = ~core_arst_n;

  // Mode is caught after power-on release, master reset release and watchdog reset.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      core_prev_r <= 1'b0;
      por_done_r <= 1'b0;
    end else begin
      core_prev_r <= core_arst_n;
      por_done_r <= 1'b1;
    end
  end
  assign mode_sample = ~por_done_r | (core_arst_n & ~core_prev_r) | watchdog_reset;
  assign enter_2w = mode_sample & mode_s2_r & ~mode_2w_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mode_2w_r <= 1'b0;
    end else if (mode_sample) begin
      mode_2w_r <= mode_s2_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      strap_r <= 1'b0;
    end else if (enter_2w || (watchdog_reset && mode_s2_r)) begin
      strap_r <= pin_s2_r;
    end
  end

  // Master clock activity keeps being watched through reset.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      idle_cnt_r <= '0;
      mclk_active_r <= 1'b0;
    end else if (am_rise) begin
      idle_cnt_r <= '0;
      mclk_active_r <= 1'b1;
    end else if (idle_cnt_r == rbpc_pkg::CNT_W'(rbpc_pkg::MCLK_IDLE_CYC - 1)) begin
      mclk_active_r <= 1'b0;
    end else begin
      idle_cnt_r <= rbpc_pkg::CNT_W'(idle_cnt_r + 1'b1);
    end
  end

  // A live master clock during reset leaves nothing to settle after release.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      su_cnt_r <= rbpc_pkg::CNT_W'(rbpc_pkg::STARTUP_CYC);
    end else if (in_reset) begin
      su_cnt_r <= mclk_active_r ? '0 : rbpc_pkg::CNT_W'(rbpc_pkg::STARTUP_CYC);
    end else if (su_cnt_r != '0) begin
      su_cnt_r <= rbpc_pkg::CNT_W'(su_cnt_r - 1'b1);
    end
  end

  assign core_clk_en = ~in_reset;
  assign input_clk_en = mclk_active_r;
  assign adc_bias_en = 1'b1;
  assign conv_operational = core_arst_n & (su_cnt_r == '0);
  assign serial_if_enable = core_arst_n;
  assign two_wire_mode = mode_2w_r;
  assign oversampling_select_low_strap = strap_r;

  // Control word shares its defaults between pin reset and power-on reset.
  always_ff @(posedge sys_clk or negedge core_arst_n) begin
    if (!core_arst_n) begin
      en_r <= rbpc_pkg::CTRL_EN_RST;
      extref_r <= rbpc_pkg::CTRL_EXTREF_RST;
    end else if (!rst_b) begin
      en_r <= rbpc_pkg::CTRL_EN_RST;
      extref_r <= rbpc_pkg::CTRL_EXTREF_RST;
    end else if (wr_do && awaddr_r == rbpc_pkg::ADDR_CTRL && wstrb_r[0]) begin
      en_r <= wdata_r[rbpc_pkg::CTRL_EN_BIT];
      extref_r <= wdata_r[rbpc_pkg::CTRL_EXTREF_BIT];
    end
  end
  assign internal_ref_en = ~extref_r;
  assign ref_pin_switch = ~extref_r;

  // Bus handshakes run on the system reset so a held pin reset cannot hang a master.
  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready = ~w_got_r & ~bvalid_r;
  assign wr_do = aw_got_r & w_got_r & ~bvalid_r & core_arst_n;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= rbpc_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (aw_got_r && w_got_r && !bvalid_r) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (in_reset || !is_mapped(awaddr_r)) ? rbpc_pkg::RESP_SLVERR : rbpc_pkg::RESP_OKAY;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  assign s_axi_arready = ~rvalid_r;
  assign rd_do = s_axi_arvalid & ~rvalid_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= rbpc_pkg::RESP_OKAY;
    end else if (rd_do) begin
      rvalid_r <= 1'b1;
      rdata_r <= '0;
      rresp_r <= rbpc_pkg::RESP_OKAY;
      if (in_reset || !is_mapped(s_axi_araddr)) begin
        rresp_r <= rbpc_pkg::RESP_SLVERR;
      end else if (s_axi_araddr == rbpc_pkg::ADDR_CTRL) begin
        rdata_r[rbpc_pkg::CTRL_EN_BIT] <= en_r;
        rdata_r[rbpc_pkg::CTRL_EXTREF_BIT] <= extref_r;
      end else begin
        rdata_r[rbpc_pkg::ST_MODE_BIT] <= mode_2w_r;
        rdata_r[rbpc_pkg::ST_STRAP_BIT] <= strap_r;
        rdata_r[rbpc_pkg::ST_RESET_BIT] <= in_reset;
        rdata_r[rbpc_pkg::ST_MCLK_BIT] <= mclk_active_r;
        rdata_r[rbpc_pkg::ST_OPER_BIT] <= conv_operational;
        rdata_r[rbpc_pkg::ST_FIFO_LSB +: rbpc_pkg::FIFO_CNT_W] <= fifo_level;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Bitstream pairs wait here for the next analog clock edge; a full FIFO stalls the source.
  assign drive_en = en_r & ~mode_2w_r;
  assign fifo_oready = am_rise | ~drive_en;
  rbpc_fifo #(
    .WIDTH(rbpc_pkg::FIFO_WIDTH),
    .DEPTH(rbpc_pkg::FIFO_DEPTH),
    .CNT_W(rbpc_pkg::FIFO_CNT_W)
  ) u_fifo (
    .clk(sys_clk),
    .arst_n(core_arst_n),
    .srst_n(rst_b),
    .in_valid(mod_valid),
    .in_data(mod_data),
    .in_ready(mod_ready),
    .out_valid(fifo_ovalid),
    .out_data(fifo_odata),
    .out_ready(fifo_oready),
    .level(fifo_level)
  );

  always_ff @(posedge sys_clk or negedge core_arst_n) begin
    if (!core_arst_n) begin
      bs0_r <= 1'b0;
      bs1_r <= 1'b0;
    end else if (!rst_b) begin
      bs0_r <= 1'b0;
      bs1_r <= 1'b0;
    end else if (am_rise && fifo_ovalid && drive_en) begin
      bs0_r <= fifo_odata[0];
      bs1_r <= fifo_odata[1];
    end
  end
  assign bitstream_out_ch0 = bs0_r;
  assign bitstream_out_ch1 = bs1_r;
  assign bitstream_out_ch0_oe = drive_en;
  assign bitstream_out_ch1_oe = drive_en;

  // Conversion-ready pulse; enabling the bitstreams cuts it short.
  always_ff @(posedge sys_clk or negedge core_arst_n) begin
    if (!core_arst_n) begin
      dr_n_r <= 1'b1;
      dr_cnt_r <= '0;
    end else if (!rst_b || en_r) begin
      dr_n_r <= 1'b1;
      dr_cnt_r <= '0;
    end else if (conv_done) begin
      dr_n_r <= 1'b0;
      dr_cnt_r <= rbpc_pkg::DR_CNT_W'(rbpc_pkg::DIGITAL_MASTER_CLOCK_HALF_CYC - 1);
    end else if (!dr_n_r) begin
      if (dr_cnt_r == '0) begin
        dr_n_r <= 1'b1;
      end else begin
        dr_cnt_r <= rbpc_pkg::DR_CNT_W'(dr_cnt_r - 1'b1);
      end
    end
  end
  assign conversion_ready_out = dr_n_r | en_r;
  assign conversion_ready_oe = ~mode_2w_r;

  always_ff @(posedge sys_clk) begin
    if (dr_n_r) begin
      dr_low_len_r <= '0;
    end else begin
      dr_low_len_r <= rbpc_pkg::DR_CNT_W'(dr_low_len_r + 1'b1);
    end
  end

  rst_defaults_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    in_reset |-> !bitstream_out_ch0_oe && internal_ref_en && conversion_ready_out) else $error("pin reset lost defaults");
  por_same_a: assert property (@(posedge sys_clk)
    $past(!rst_b) |-> !en_r && !extref_r) else $error("power-on state differs");
  bus_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(bvalid_r) && $past(in_reset) |-> bresp_r == rbpc_pkg::RESP_SLVERR && $stable(en_r))
    else $error("write taken in reset");
  clk_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    in_reset |-> !core_clk_en && !serial_if_enable && input_clk_en == mclk_active_r) else $error("clock gating wrong");
  fast_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(core_arst_n) && $past(mclk_active_r) |-> conv_operational && adc_bias_en) else $error("start-up delay");
  strap_catch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(mode_2w_r) |-> strap_r == $past(pin_s2_r)) else $error("strap not caught");
  ref_select_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_do && awaddr_r == rbpc_pkg::ADDR_CTRL && wstrb_r[0]
    |=> internal_ref_en == !$past(wdata_r[rbpc_pkg::CTRL_EXTREF_BIT]) && ref_pin_switch == internal_ref_en)
    else $error("reference select wrong");
  pin_float_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !en_r |-> !bitstream_out_ch0_oe && !bitstream_out_ch1_oe) else $error("bitstream pin driven");
  two_wire_float_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode_2w_r && en_r |-> !bitstream_out_ch0_oe && !bitstream_out_ch1_oe) else $error("driven in 2-wire");
  bs_update_a: assert property (@(posedge sys_clk) disable iff (!rst_b || in_reset)
    am_rise && fifo_ovalid && drive_en |=> bs0_r == $past(fifo_odata[0]) && bs1_r == $past(fifo_odata[1]))
    else $error("bitstream not updated");
  dr_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    en_r |-> conversion_ready_out) else $error("ready not suppressed");
  dr_width_a: assert property (@(posedge sys_clk) disable iff (!rst_b || in_reset)
    $rose(dr_n_r) && !$past(en_r) && !$past(conv_done)
    |-> dr_low_len_r == rbpc_pkg::DR_CNT_W'(rbpc_pkg::DIGITAL_MASTER_CLOCK_HALF_CYC)) else $error("ready pulse width");
  mode_catch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(core_arst_n) |=> mode_2w_r == $past(mode_s2_r)) else $error("mode not caught");
  sync_release_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !$past(hard_arst_n) |-> in_reset) else $error("release not in step");

  enter_2w_c: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(mode_2w_r));
  dr_pulse_c: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(dr_n_r));
  bs_drive_c: cover property (@(posedge sys_clk) disable iff (!rst_b) am_rise && fifo_ovalid && drive_en);
  fifo_full_c: cover property (@(posedge sys_clk) disable iff (!rst_b) !mod_ready);
endmodule

// ==== verif/rbpc_host_model.sv ====
// Purpose: Host-side model that drives the reset, mode and master clock pins.
// Assumes: The bench changes the controls right after a sys_clk edge.
// Notes: The master clock has an 85 ns half period, unrelated to sys_clk.
`timescale 1ns/1ps
module rbpc_host_model (
  // Controls from the bench.
  input wire logic clk_run,
  input wire logic hold_reset,
  input wire logic two_wire_sel,
  input wire logic strap_val,
  // Pins.
  output logic analog_master_clock,
  output logic reset_oversampling_select_low_strap_pin,
  output logic mode_pin
);
  // A stopped clock stands still, which stalls the bitstream drain.
  initial begin
    analog_master_clock = 1'h0;
    forever begin
      #85;
      analog_master_clock = clk_run ? ~analog_master_clock : analog_master_clock;
    end
  end
  // In 2-wire mode the shared pin carries the strap level instead of the reset.
  assign reset_oversampling_select_low_strap_pin = two_wire_sel ? strap_val : ~hold_reset;
  assign mode_pin = two_wire_sel;
endmodule

// ==== verif/tb_rbpc_top.sv ====
// Purpose: Self-checking bench for the reset and bitstream pin control block.
// Assumes: The host model drives the reset, mode and master clock pins.
// Notes: A watcher checks bus answers and bitstream values against queued notes.
`timescale 1ns/1ps
module tb_rbpc_top;
  localparam logic [1:0] OK = rbpc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = rbpc_pkg::RESP_SLVERR;
  localparam logic [3:0] CT = rbpc_pkg::ADDR_CTRL;
  logic sys_clk, rst_b, watchdog_reset, conv_done, mod_valid, mod_ready;
  logic [1:0] mod_data, v;
  logic [1:0] last_bits = 2'h0;
  logic reset_oversampling_select_low_strap_pin, mode_pin, analog_master_clock, clk_run, hold_reset, two_wire_sel, strap_val;
  logic bitstream_out_ch0, bitstream_out_ch0_oe, bitstream_out_ch1, bitstream_out_ch1_oe;
  logic conversion_ready_out, conversion_ready_oe, core_clk_en, input_clk_en, adc_bias_en;
  logic conv_operational, serial_if_enable, two_wire_mode, oversampling_select_low_strap;
  logic internal_ref_en, ref_pin_switch;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] resp_q[$];
  logic [1:0] bits_q[$];
  integer seed = 32'h81A845A7;
  int n_mismatch = 0;
  int checks = 0;
  int cnt;
  rbpc_top dut_u (.sys_clk, .rst_b, .reset_oversampling_select_low_strap_pin, .mode_pin, .analog_master_clock, .bitstream_out_ch0,
    .bitstream_out_ch0_oe, .bitstream_out_ch1, .bitstream_out_ch1_oe, .conversion_ready_out,
    .conversion_ready_oe, .watchdog_reset, .conv_done, .mod_valid, .mod_data, .mod_ready, .core_clk_en,
    .input_clk_en, .adc_bias_en, .conv_operational, .serial_if_enable, .two_wire_mode,
    .oversampling_select_low_strap, .internal_ref_en, .ref_pin_switch, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  rbpc_host_model host_u (.clk_run, .hold_reset, .two_wire_sel, .strap_val, .analog_master_clock,
    .reset_oversampling_select_low_strap_pin, .mode_pin);
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic fail_wait(input string nm);
    n_mismatch++;
    $display("unexpected %s expected an answer seen none", nm);
    report_and_stop();
  endtask
  task automatic check_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Takes the oldest note of the bus or the bitstream queue.
  task automatic check_note(input string nm, input logic [33:0] g, input bit strm);
    logic [33:0] e;
    e = 34'h3_FFFF_FFFF;
    if (strm && bits_q.size() > 0) e = {32'h0, bits_q.pop_front()};
    if (!strm && resp_q.size() > 0) e = resp_q.pop_front();
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One write or read; a read expects data d.
  task automatic axi(input bit wr, input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad;
    bit w;
    bit b;
    int n;
    ad = 1'h1;
    w = wr;
    b = 1'h1;
    n = 0;
    @(posedge sys_clk);
    resp_q.push_back(wr ? {er, 32'h0} : {er, d});
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    while (ad || w || b) begin
      @(posedge sys_clk);
      n++;
      ad = ad && !(wr ? s_axi_awready : s_axi_arready);
      w = w && !s_axi_wready;
      b = b && !(wr ? s_axi_bvalid : s_axi_rvalid);
      s_axi_awvalid <= ad && wr;
      s_axi_arvalid <= ad && !wr;
      s_axi_wvalid <= w;
      s_axi_bready <= b && wr;
      s_axi_rready <= b && !wr;
      if (n > 100) fail_wait("axi");
    end
  endtask
  task automatic push();
    int n;
    n = 0;
    mod_valid <= 1'h1;
    @(posedge sys_clk);
    while (mod_ready !== 1'h1) begin
      @(posedge sys_clk);
      n++;
      if (n > 2000) fail_wait("mod_ready");
    end
    bits_q.push_back(mod_data);
  endtask
  task automatic conv_pulse();
    conv_done <= 1'h1;
    @(posedge sys_clk);
    conv_done <= 1'h0;
    cnt = 0;
    repeat (20) begin
      @(posedge sys_clk);
      cnt += (conversion_ready_out === 1'h0);
    end
  endtask
  // Lets a pin change pass the two-flop synchroniser before the watchdog samples it.
  task automatic wd_pulse();
    tick(3);
    watchdog_reset <= 1'h1;
    @(posedge sys_clk);
    watchdog_reset <= 1'h0;
    tick(4);
  endtask
  always @(posedge sys_clk) begin
    if (s_axi_bvalid && s_axi_bready) check_note("bresp", {s_axi_bresp, 32'h0}, 1'h0);
    if (s_axi_rvalid && s_axi_rready) check_note("rdata", {s_axi_rresp, s_axi_rdata}, 1'h0);
    if (bitstream_out_ch0_oe && {bitstream_out_ch1, bitstream_out_ch0} !== last_bits) begin
      check_note("bitstream", {32'h0, bitstream_out_ch1, bitstream_out_ch0}, 1'h1);
      last_bits = {bitstream_out_ch1, bitstream_out_ch0};
    end
  end
  initial begin
    rst_b = 1'h0;
    {clk_run, hold_reset, two_wire_sel, strap_val, watchdog_reset, conv_done, mod_valid} = 7'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mod_data, v} = 44'h0;
    s_axi_wstrb = 4'hF;
    tick(10);
    rst_b <= 1'h1;
    clk_run <= 1'h1;
    tick(4);
    axi(1'h1, CT, 32'h2, OK);
    check_bit("internal_ref_en", 1'h0, internal_ref_en);
    check_bit("ref_pin_switch", 1'h0, ref_pin_switch);
    axi(1'h0, CT, 32'h2, OK);
    axi(1'h1, CT, 32'h0, OK);
    check_bit("internal_ref_en", 1'h1, internal_ref_en);
    check_bit("ref_pin_switch", 1'h1, ref_pin_switch);
    axi(1'h0, 4'h8, 32'h0, ERR);
    conv_pulse();
    check_bit("ready_pulse_width", 1'h1, cnt == rbpc_pkg::DIGITAL_MASTER_CLOCK_HALF_CYC);
    check_bit("conversion_ready_oe", 1'h1, conversion_ready_oe);
    $display("test reference and ready pulse done");
    clk_run <= 1'h0;
    axi(1'h1, CT, 32'h1, OK);
    check_bit("bitstream_out_ch1_oe", 1'h1, bitstream_out_ch1_oe);
    conv_pulse();
    check_bit("ready_held_off", 1'h1, cnt == 0);
    for (int i = 0; i < 9; i++) begin
      v = v + (($random(seed) & 1) ? 2'h2 : 2'h1);
      mod_data <= v;
      if (i == 8) begin
        tick(3);
        check_bit("mod_ready", 1'h0, mod_ready);
        clk_run <= 1'h1;
      end
      push();
    end
    mod_valid <= 1'h0;
    cnt = 0;
    while (bits_q.size() > 0) begin
      @(posedge sys_clk);
      cnt++;
      if (cnt > 3000) fail_wait("bitstream");
    end
    $display("test bitstream drain done");
    hold_reset <= 1'h1;
    #2;
    check_bit("core_clk_en", 1'h0, core_clk_en);
    tick(4);
    check_bit("input_clk_en", 1'h1, input_clk_en);
    check_bit("adc_bias_en", 1'h1, adc_bias_en);
    check_bit("serial_if_enable", 1'h0, serial_if_enable);
    check_bit("bitstream_out_ch0_oe", 1'h0, bitstream_out_ch0_oe);
    axi(1'h1, CT, 32'h1, ERR);
    axi(1'h0, CT, 32'h0, ERR);
    hold_reset <= 1'h0;
    tick(1);
    check_bit("core_clk_en", 1'h0, core_clk_en);
    tick(4);
    check_bit("conv_operational", 1'h1, conv_operational);
    axi(1'h0, CT, 32'h0, OK);
    $display("test pin reset done");
    strap_val <= 1'h1;
    two_wire_sel <= 1'h1;
    tick(4);
    check_bit("two_wire_mode", 1'h0, two_wire_mode);
    wd_pulse();
    check_bit("two_wire_mode", 1'h1, two_wire_mode);
    check_bit("strap", 1'h1, oversampling_select_low_strap);
    check_bit("conversion_ready_oe", 1'h0, conversion_ready_oe);
    axi(1'h0, rbpc_pkg::ADDR_STATUS, 32'h1B, OK);
    axi(1'h1, CT, 32'h1, OK);
    check_bit("bitstream_out_ch0_oe", 1'h0, bitstream_out_ch0_oe);
    strap_val <= 1'h0;
    wd_pulse();
    check_bit("strap", 1'h0, oversampling_select_low_strap);
    check_bit("core_clk_en", 1'h1, core_clk_en);
    axi(1'h1, CT, 32'h0, OK);
    strap_val <= 1'h1;
    two_wire_sel <= 1'h0;
    wd_pulse();
    check_bit("two_wire_mode", 1'h0, two_wire_mode);
    $display("test two wire mode done");
    report_and_stop();
  end
endmodule
